// ---- hdl/tcwm_pkg.sv ----
/*
 * Constants, register map and pin-action helpers of the waveform-mode
 * timer channel. Assumes a 32-bit APB master and one 100 MHz system clock.
 */
package tcwm_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_CMD   = 8'h00;
  localparam logic [7:0]  ADDR_CFG   = 8'h04;
  localparam logic [7:0]  ADDR_CNT   = 8'h10;
  localparam logic [7:0]  ADDR_CMPA  = 8'h14;
  localparam logic [7:0]  ADDR_CMPB  = 8'h18;
  localparam logic [7:0]  ADDR_PER   = 8'h1c;
  localparam logic [7:0]  ADDR_STAT  = 8'h20;

  // ==========================================================
  // Field positions of channel_waveform_config
  localparam int CFG_CLKS    = 0;
  localparam int CFG_INV     = 3;
  localparam int CFG_GATE    = 4;
  localparam int CFG_STOP    = 6;
  localparam int CFG_DIS     = 7;
  localparam int CFG_EDGE    = 8;
  localparam int CFG_EVSRC   = 10;
  localparam int CFG_RESTART = 12;
  localparam int CFG_UPDN    = 13;
  localparam int CFG_AUTO    = 14;
  localparam int CFG_WAVE    = 15;
  localparam int CFG_A_CMP   = 16;
  localparam int CFG_A_PER   = 18;
  localparam int CFG_A_EVT   = 20;
  localparam int CFG_A_SW    = 22;
  localparam int CFG_B_CMP   = 24;
  localparam int CFG_B_PER   = 26;
  localparam int CFG_B_EVT   = 28;
  localparam int CFG_B_SW    = 30;

  // Command and status bit positions
  localparam int CMD_CLKEN   = 0;
  localparam int CMD_CLKDIS  = 1;
  localparam int CMD_TRIG    = 2;
  localparam int STAT_CLKON  = 16;
  localparam int STAT_PINA   = 17;
  localparam int STAT_PINB   = 18;

  // ==========================================================
  // Internal clock taps on the free-running prescaler
  localparam int PRESC_W     = 16;
  localparam int TAP_CLK1    = 0;
  localparam int TAP_CLK2    = 2;
  localparam int TAP_CLK3    = 4;
  localparam int TAP_CLK4    = 6;
  localparam int TAP_CLK5    = 15;

  // ==========================================================
  // Encodings and reset values
  localparam logic [2:0]  SEL_CLK1   = 3'h0;
  localparam logic [2:0]  SEL_CLK2   = 3'h1;
  localparam logic [2:0]  SEL_CLK3   = 3'h2;
  localparam logic [2:0]  SEL_CLK4   = 3'h3;
  localparam logic [2:0]  SEL_CLK5   = 3'h4;
  localparam logic [2:0]  SEL_EXT0   = 3'h5;
  localparam logic [2:0]  SEL_EXT1   = 3'h6;
  localparam logic [2:0]  SEL_EXT2   = 3'h7;
  localparam logic [1:0]  GATE_NONE  = 2'h0;
  localparam logic [1:0]  GATE_EXT0  = 2'h1;
  localparam logic [1:0]  GATE_EXT1  = 2'h2;
  localparam logic [1:0]  EDGE_NONE  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_FALL  = 2'h2;
  localparam logic [1:0]  EVSRC_PINB = 2'h0;
  localparam logic [1:0]  EVSRC_EXT0 = 2'h1;
  localparam logic [1:0]  EVSRC_EXT1 = 2'h2;
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_SET    = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_STEP   = 16'h0001;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ==========================================================
  // Pin action helpers
  function automatic logic [1:0] tcwm_pick(input logic [3:0] hit,
                                           input logic [7:0] act);
    // hit/act order: [3] soft trigger, [2] event, [1] period, [0] compare
    logic [1:0] r;
    r = ACT_NONE;
    for (int i = 0; i < 4; i++) begin
      if (hit[i] && act[2*i +: 2] != ACT_NONE) begin
        r = act[2*i +: 2];
      end
    end
    return r;
  endfunction

  function automatic logic tcwm_apply(input logic cur,
                                      input logic [1:0] act);
    logic r;
    r = cur;
    unique case (act)
      ACT_NONE:  r = cur;
      ACT_SET:   r = 1'b1;
      ACT_CLEAR: r = 1'b0;
      default:   r = ~cur;
    endcase
    return r;
  endfunction

endpackage

// ---- hdl/tcwm_clk_sel.sv ----
/*
 * Counter clock selection, gating and edge pick for the timer channel.
 * Assumes external clock lines are synchronous to the system clock; the
 * tick output is a registered one-cycle pulse per active counter edge.
 */
`timescale 1ns/1ns
module tcwm_clk_sel
  import tcwm_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               rst_b_in,
  input  wire logic [2:0]         sel_in,
  input  wire logic               invert_in,
  input  wire logic [1:0]         gate_in,
  input  wire logic [PRESC_W-1:0] presc_in,
  input  wire logic [2:0]         xc_in,
  output      logic               tick_out
);

  typedef struct packed {
    logic lvl;
    logic tick;
  } tcwm_sel_t;

  tcwm_sel_t s_r;
  tcwm_sel_t s_nxt;
  logic      src;
  logic      gate;
  logic      lvl;

  // ==========================================================
  // Source and gate
  always_comb begin
    unique case (sel_in)
      SEL_CLK1: src = presc_in[TAP_CLK1];
      SEL_CLK2: src = presc_in[TAP_CLK2];
      SEL_CLK3: src = presc_in[TAP_CLK3];
      SEL_CLK4: src = presc_in[TAP_CLK4];
      SEL_CLK5: src = presc_in[TAP_CLK5];
      SEL_EXT0: src = xc_in[0];
      SEL_EXT1: src = xc_in[1];
      SEL_EXT2: src = xc_in[2];
    endcase
    unique case (gate_in)
      GATE_NONE: gate = 1'b1;
      GATE_EXT0: gate = xc_in[0];
      GATE_EXT1: gate = xc_in[1];
      default:   gate = xc_in[2];
    endcase
    lvl = src & gate;
    s_nxt = s_r;
    s_nxt.lvl = lvl;
    // Falling edge when inverted, rising edge otherwise
    s_nxt.tick = invert_in ? (s_r.lvl & ~lvl)
                           : (~s_r.lvl & lvl);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;

endmodule

// ---- hdl/tcwm_top.sv ----
/*
 * Waveform-mode timer channel: 16-bit counter, compare registers, two
 * waveform pins and an APB register slave.
 * Assumes APB signals and all pin inputs synchronous to clk_sys_in.
 */
// Summary of operation
// - clock select picks internal or external clock
// - invert bit counts on falling edge
// - gate field ANDs clock with external line
// - period match stops clock when enabled, except where an up-count auto trigger restarts it
// - period match disables clock when enabled
// - event edge none, rise, fall, both
// - event source pin B or external lines
// - pin B as event input stops waveform
// - restart enable: event clears counter and ends a period stop
// - restart off: event only drives pin A
// - shape: up or up/down, auto trigger
// - waveform bit enables waveform behaviour
// - pin A actions none/set/clear/toggle
// - pin B actions none/set/clear/toggle
// - live count readable, upper bits zero
// - compare A writable only in waveform mode
// - compare B writable only in waveform mode
// - period register always read/write
// - soft trigger clears counter, ends a period stop
`timescale 1ns/1ns
module tcwm_top
  import tcwm_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output      logic [31:0] prdata_out,
  output      logic        pready_out,
  output      logic        pslverr_out,
  input  wire logic [2:0]  xc_in,
  input  wire logic        io_a_in,
  input  wire logic        io_b_in,
  output      logic        io_a_out,
  output      logic        io_a_oe_out,
  output      logic        io_b_out,
  output      logic        io_b_oe_out
);

  typedef struct packed {
    logic [31:0]        cfg;
    logic [15:0]        cnt;
    logic [15:0]        cmpa;
    logic [15:0]        cmpb;
    logic [15:0]        per;
    logic               down;
    logic               clk_on;
    logic               stopped;
    logic               pin_a;
    logic               pin_b;
    logic               pin_b_oe;
    logic               ev_prev;
    logic               ev_arm;
    logic [PRESC_W-1:0] presc;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } tcwm_state_t;

  // ==========================================================
  // Reset release
  logic [1:0]  rst_sync_r;
  logic        rst_b;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  tcwm_state_t s_r;
  tcwm_state_t s_nxt;
  logic        tick;
  logic        wave;
  logic        wr_acc;
  logic        sw_trg;
  logic        ev_sig;
  logic        ev_hit;
  logic        run;
  logic        hit_a;
  logic        hit_b;
  logic        hit_p;
  logic        trig;
  logic        hold;
  logic        auto_trg;
  logic        pin_b_in_mode;
  logic [15:0] top_val;

  // ==========================================================
  // Counter clock
  tcwm_clk_sel u_clk_sel (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b),
    .sel_in     (s_r.cfg[CFG_CLKS +: 3]),
    .invert_in  (s_r.cfg[CFG_INV]),
    .gate_in    (s_r.cfg[CFG_GATE +: 2]),
    .presc_in   (s_r.presc),
    .xc_in      (xc_in),
    .tick_out   (tick)
  );

  function automatic logic tcwm_mapped(input logic [7:0] a);
    return a == ADDR_CMD || a == ADDR_CFG || a == ADDR_CNT ||
           a == ADDR_CMPA || a == ADDR_CMPB || a == ADDR_PER ||
           a == ADDR_STAT;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.presc = s_r.presc + {{(PRESC_W-1){1'b0}}, 1'b1};
    wave = s_r.cfg[CFG_WAVE];
    pin_b_in_mode = s_r.cfg[CFG_EVSRC +: 2] == EVSRC_PINB;
    wr_acc = psel_in & penable_in & s_r.pready & pwrite_in;
    sw_trg = wr_acc & (paddr_in == ADDR_CMD) & pwdata_in[CMD_TRIG];

    // External event select and edge detect
    unique case (s_r.cfg[CFG_EVSRC +: 2])
      EVSRC_PINB: ev_sig = io_b_in;
      EVSRC_EXT0: ev_sig = xc_in[0];
      EVSRC_EXT1: ev_sig = xc_in[1];
      default:    ev_sig = xc_in[2];
    endcase
    s_nxt.ev_prev = ev_sig;
    // A config write may swap the event source; skip one cycle so the
    // old source's level cannot pose as an edge
    s_nxt.ev_arm = ~(wr_acc & (paddr_in == ADDR_CFG));
    unique case (s_r.cfg[CFG_EDGE +: 2])
      EDGE_NONE: ev_hit = 1'b0;
      EDGE_RISE: ev_hit = ~s_r.ev_prev & ev_sig;
      EDGE_FALL: ev_hit = s_r.ev_prev & ~ev_sig;
      default:   ev_hit = s_r.ev_prev ^ ev_sig;
    endcase
    ev_hit = ev_hit & wave & s_r.ev_arm;

    // Compare matches on the value held during this counter cycle
    run   = tick & s_r.clk_on & ~s_r.stopped;
    hit_a = run & wave & (s_r.cnt == s_r.cmpa);
    hit_b = run & wave & (s_r.cnt == s_r.cmpb);
    hit_p = run & (s_r.cnt == s_r.per);
    auto_trg = s_r.cfg[CFG_AUTO] & wave;
    trig = sw_trg
         | (ev_hit & s_r.cfg[CFG_RESTART])
         | (hit_p & auto_trg & ~s_r.cfg[CFG_UPDN]);
    top_val = auto_trg ? s_r.per : CNT_MAX;
    // Stop or disable keeps the count on the period value; a same-cycle trigger clears it instead
    hold = hit_p & wave & (s_r.cfg[CFG_STOP] | s_r.cfg[CFG_DIS]);

    // Counting
    if (trig) begin
      s_nxt.cnt = CNT_ZERO;
      s_nxt.down = 1'b0;
      s_nxt.stopped = 1'b0;
    end else if (run && !hold) begin
      if (wave && s_r.cfg[CFG_UPDN]) begin
        if (!s_r.down && s_r.cnt == top_val) begin
          s_nxt.down = 1'b1;
          s_nxt.cnt = s_r.cnt - CNT_STEP;
        end else if (s_r.down && s_r.cnt == CNT_ZERO) begin
          s_nxt.down = 1'b0;
          s_nxt.cnt = s_r.cnt + CNT_STEP;
        end else begin
          s_nxt.cnt = s_r.down ? s_r.cnt - CNT_STEP
                               : s_r.cnt + CNT_STEP;
        end
      end else begin
        // Natural 16-bit wrap at the top
        s_nxt.cnt = s_r.cnt + CNT_STEP;
      end
    end
    if (hit_p && wave && s_r.cfg[CFG_STOP] && !trig) begin
      s_nxt.stopped = 1'b1;
    end

    // Clock enable commands; a period disable beats a same-cycle enable
    if (wr_acc && paddr_in == ADDR_CMD) begin
      if (pwdata_in[CMD_CLKDIS]) begin
        s_nxt.clk_on = 1'b0;
      end else if (pwdata_in[CMD_CLKEN]) begin
        s_nxt.clk_on = 1'b1;
      end
    end
    if (hit_p && wave && s_r.cfg[CFG_DIS]) begin
      s_nxt.clk_on = 1'b0;
    end

    // Waveform pins; event reaches pin B only with restart enabled
    if (wave) begin
      s_nxt.pin_a = tcwm_apply(s_r.pin_a, tcwm_pick(
        {sw_trg, ev_hit, hit_p, hit_a},
        {s_r.cfg[CFG_A_SW +: 2], s_r.cfg[CFG_A_EVT +: 2],
         s_r.cfg[CFG_A_PER +: 2], s_r.cfg[CFG_A_CMP +: 2]}));
      if (!pin_b_in_mode) begin
        s_nxt.pin_b = tcwm_apply(s_r.pin_b, tcwm_pick(
          {sw_trg, ev_hit & s_r.cfg[CFG_RESTART], hit_p, hit_b},
          {s_r.cfg[CFG_B_SW +: 2], s_r.cfg[CFG_B_EVT +: 2],
           s_r.cfg[CFG_B_PER +: 2], s_r.cfg[CFG_B_CMP +: 2]}));
      end
    end

    // Register writes
    if (wr_acc) begin
      unique case (paddr_in)
        ADDR_CFG:  s_nxt.cfg = pwdata_in;
        ADDR_CMPA: if (wave) s_nxt.cmpa = pwdata_in[15:0];
        ADDR_CMPB: if (wave) s_nxt.cmpb = pwdata_in[15:0];
        ADDR_PER:  s_nxt.per = pwdata_in[15:0];
        default:   s_nxt.per = s_r.per;
      endcase
    end

    // Direction follows the new config at once, so a level still driven
    // by the channel never reaches the event detector
    s_nxt.pin_b_oe = s_nxt.cfg[CFG_WAVE] &
                     (s_nxt.cfg[CFG_EVSRC +: 2] != EVSRC_PINB);

    // APB: answer is prepared in the setup cycle, so no wait states
    s_nxt.pready = psel_in & ~penable_in;
    s_nxt.pslverr = psel_in & ~penable_in & ~tcwm_mapped(paddr_in);
    s_nxt.prdata = WORD_ZERO;
    if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        ADDR_CFG:  s_nxt.prdata = s_r.cfg;
        ADDR_CNT:  s_nxt.prdata[15:0] = s_r.cnt;
        ADDR_CMPA: s_nxt.prdata[15:0] = s_r.cmpa;
        ADDR_CMPB: s_nxt.prdata[15:0] = s_r.cmpb;
        ADDR_PER:  s_nxt.prdata[15:0] = s_r.per;
        ADDR_STAT: begin
          s_nxt.prdata[STAT_CLKON] = s_r.clk_on & ~s_r.stopped;
          // Pins that are not driven mirror the level seen on the wire
          s_nxt.prdata[STAT_PINA] = wave ? s_r.pin_a : io_a_in;
          s_nxt.prdata[STAT_PINB] = s_r.pin_b_oe ? s_r.pin_b : io_b_in;
        end
        default:   s_nxt.prdata = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out  = s_r.prdata;
  assign pready_out  = s_r.pready;
  assign pslverr_out = s_r.pslverr;
  assign io_a_out    = s_r.pin_a;
  assign io_a_oe_out = s_r.cfg[CFG_WAVE];
  assign io_b_out    = s_r.pin_b;
  assign io_b_oe_out = s_r.pin_b_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b);

  a_cmpa_locked: assert property (
    wr_acc && paddr_in == ADDR_CMPA && !wave |=> $stable(s_r.cmpa))
    else $error("compare A changed outside waveform mode");

  a_cmpb_written: assert property (
    wr_acc && paddr_in == ADDR_CMPB && wave
    |=> s_r.cmpb == $past(pwdata_in[15:0]))
    else $error("compare B write lost");

  a_period_write: assert property (
    wr_acc && paddr_in == ADDR_PER |=> s_r.per == $past(pwdata_in[15:0]))
    else $error("period write lost");

  a_soft_restart: assert property (
    sw_trg |=> s_r.cnt == CNT_ZERO && !s_r.stopped)
    else $error("soft trigger did not restart counter");

  a_event_restart: assert property (
    ev_hit && s_r.cfg[CFG_RESTART] |=> s_r.cnt == CNT_ZERO)
    else $error("event did not clear counter");

  a_event_passive: assert property (
    ev_hit && !s_r.cfg[CFG_RESTART] && !sw_trg && !run
    |=> $stable(s_r.cnt))
    else $error("event moved counter without restart");

  a_stop_match: assert property (
    hit_p && wave && s_r.cfg[CFG_STOP] && !trig
    |=> s_r.stopped ##1 !run)
    else $error("period match did not stop clock");

  a_disable_match: assert property (
    hit_p && wave && s_r.cfg[CFG_DIS] |=> !s_r.clk_on)
    else $error("period match did not disable clock");

  a_up_wrap: assert property (
    run && !trig && !hold && s_r.cnt == CNT_MAX && !s_r.cfg[CFG_UPDN]
    |=> s_r.cnt == CNT_ZERO)
    else $error("counter did not wrap");

  a_pinb_input: assert property (
    pin_b_in_mode |-> !io_b_oe_out ##1 $stable(io_b_out))
    else $error("pin B driven while event input");

  a_soft_pin_a: assert property (
    sw_trg && wave && s_r.cfg[CFG_A_SW +: 2] == ACT_SET |=> io_a_out)
    else $error("soft trigger action on pin A lost");

  a_match_hold: assert property (
    hold && !trig |=> s_r.cnt == $past(s_r.cnt))
    else $error("count moved past a stopping period match");

  a_event_quiet: assert property (
    wr_acc && paddr_in == ADDR_CFG |=> !ev_hit)
    else $error("config write raised an event");

  a_pinb_drive: assert property (
    io_b_oe_out == (wave && !pin_b_in_mode))
    else $error("pin B direction does not follow config");

  a_disable_cmd: assert property (
    wr_acc && paddr_in == ADDR_CMD && pwdata_in[CMD_CLKDIS] |=> !s_r.clk_on)
    else $error("clock disable command lost");

  a_apb_ready: assert property (
    psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("APB ready timing wrong");

  c_soft_trigger: cover property (sw_trg ##1 run);
  c_auto_trigger: cover property (hit_p && auto_trg ##1 s_r.cnt == CNT_ZERO);
  c_updown_turn:  cover property (run && s_r.down ##1 !s_r.down);
  c_event_pin_a:  cover property (ev_hit ##1 $changed(io_a_out));
  c_stop_hold:    cover property (hold ##1 s_r.stopped);

endmodule

// ---- verif/tcwm_far_model.sv ----
/*
 * Far-side model of the timer channel: the three external clock lines
 * and the wire levels of both waveform pins.
 * Assumes its tasks are called just after a rising system clock edge.
 */
`timescale 1ns/1ns
module tcwm_far_model (
  input  wire logic       clk_sys_in,
  input  wire logic       pin_a_drv_in,
  input  wire logic       pin_a_oe_in,
  input  wire logic       pin_b_drv_in,
  input  wire logic       pin_b_oe_in,
  output      logic [2:0] xc_out,
  output      logic       pin_a_out,
  output      logic       pin_b_out
);
  logic far_b_r;

  initial begin
    xc_out  = 3'h0;
    far_b_r = 1'b0;
  end

  // ==========================================================
  // Pin wires
  // Pin A has a pull-down, so a released pin never shows a stale level
  assign pin_a_out = pin_a_oe_in ? pin_a_drv_in : 1'b0;
  assign pin_b_out = pin_b_oe_in ? pin_b_drv_in : far_b_r;

  // ==========================================================
  // Clock lines stand still except while a burst is asked for
  task automatic pulse_line(input int idx, input int n, input int w);
    repeat (n) begin
      repeat (w) @(posedge clk_sys_in);
      xc_out[idx] <= ~xc_out[idx];
    end
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic drive_b(input logic lvl);
    far_b_r <= lvl;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule

// ---- verif/testbench.sv ----
/*
 * Self-checking bench of the waveform-mode timer channel: APB master,
 * answer scoreboard and far-side model.
 * Assumes the package register map and one 100 MHz clock.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench
  import tcwm_pkg::*;
  ;
  typedef struct packed {
    logic        wr;
    logic [31:0] data;
    logic        err;
  } tcwm_note_t;

  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  xc;
  logic        pin_a;
  logic        pin_b;
  logic        io_a;
  logic        io_a_oe;
  logic        io_b;
  logic        io_b_oe;
  logic [31:0] seed;
  logic [31:0] v;
  logic        a_e;
  logic        b_e;
  logic [1:0]  c;
  tcwm_note_t  note;
  tcwm_note_t  expq[$];
  int          miscompares;
  int          cmp_count;

  tcwm_top DUT (
    .clk_sys_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .xc_in(xc), .io_a_in(pin_a), .io_b_in(pin_b),
    .io_a_out(io_a), .io_a_oe_out(io_a_oe), .io_b_out(io_b),
    .io_b_oe_out(io_b_oe)
  );

  tcwm_far_model far (
    .clk_sys_in(clk), .pin_a_drv_in(io_a), .pin_a_oe_in(io_a_oe),
    .pin_b_drv_in(io_b), .pin_b_oe_in(io_b_oe), .xc_out(xc),
    .pin_a_out(pin_a), .pin_b_out(pin_b)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic act(input logic cur, input logic [1:0] code);
    case (code)
      2'h1: return 1'b1;
      2'h2: return 1'b0;
      2'h3: return ~cur;
      default: return cur;
    endcase
  endfunction

  function automatic logic [31:0] stat(input logic a, input logic b,
                                       input logic on);
    return {13'h0000, b, a, on, 16'h0000};
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Every transfer notes its expected answer before the access edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    expq.push_back({w, e, !(a inside {ADDR_CMD, ADDR_CFG, ADDR_CNT,
                    ADDR_CMPA, ADDR_CMPB, ADDR_PER, ADDR_STAT})});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, WORD_ZERO);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, e);
  endtask

  // Restart by soft trigger, feed n line toggles, read the count
  task automatic run_count(input logic [31:0] cfg, input logic [15:0] per,
                           input int idx, input int n,
                           input logic [15:0] ex);
    wr(ADDR_CFG, cfg);
    wr(ADDR_PER, {16'h0000, per});
    wr(ADDR_CMD, 32'h0000_0005);
    far.pulse_line(idx, n, 2 + int'(rnd() % 3));
    rd(ADDR_CNT, {16'h0000, ex});
  endtask

  // ==========================================================
  // Answer monitor
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK("answer", 1'b0, pready)
      end else begin
        note = expq.pop_front();
        `CHK("pslverr", note.err, pslverr)
        if (!note.wr) `CHK("prdata", note.data, prdata)
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; seed = 32'h0000_f55d;
    miscompares = 0; cmp_count = 0; a_e = 1'b0; b_e = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CFG, WORD_ZERO);
    rd(ADDR_CNT, WORD_ZERO);
    rd(ADDR_STAT, WORD_ZERO);
    rd(8'h08, WORD_ZERO);
    `CHK("oe_a", 1'b0, io_a_oe)
    v = rnd();
    wr(ADDR_CMPA, {16'h0000, v[15:0]});
    rd(ADDR_CMPA, WORD_ZERO);
    wr(ADDR_CMPB, {16'h0000, v[31:16]});
    rd(ADDR_CMPB, WORD_ZERO);
    wr(ADDR_PER, {16'h0000, v[15:0]});
    rd(ADDR_PER, {16'h0000, v[15:0]});
    wr(ADDR_CNT, v);
    rd(ADDR_CNT, WORD_ZERO);
    wr(ADDR_CFG, 32'h0000_8c05);
    rd(ADDR_CFG, 32'h0000_8c05);
    wr(ADDR_CMPA, {16'h0000, v[15:0]});
    rd(ADDR_CMPA, {16'h0000, v[15:0]});
    wr(ADDR_CMPB, {16'h0000, v[31:16]});
    rd(ADDR_CMPB, {16'h0000, v[31:16]});
    `CHK("oe_a", 1'b1, io_a_oe)
    `CHK("oe_b", 1'b1, io_b_oe)
    // Soft trigger through every action code on both pins
    for (int i = 0; i < 5; i++) begin
      c = 2'(10'h0ed >> (2 * i));
      wr(ADDR_CFG, 32'h0000_8c05 | {c, 6'h00, c, 22'h000000});
      wr(ADDR_CMD, 32'h0000_0004);
      a_e = act(a_e, c);
      b_e = act(b_e, c);
      rd(ADDR_STAT, stat(a_e, b_e, 1'b0));
    end
    `CHK("pin_b", b_e, io_b)
    run_count(32'h0000_8c16, 16'h0000, 1, 12, 16'h0000);
    run_count(32'h0000_8c05, 16'h0000, 0, 12, 16'h0006);
    run_count(32'h0000_8c0d, 16'h0000, 0, 11, 16'h0005);
    run_count(32'h0000_8c45, 16'h0003, 0, 12, 16'h0003);
    run_count(32'h0000_cc05, 16'h0003, 0, 12, 16'h0002);
    run_count(32'h0000_ec05, 16'h0003, 0, 14, 16'h0001);
    run_count(32'h0000_8c16, 16'h0000, 1, 12, 16'h0006);
    run_count(32'h0000_8c07, 16'h0000, 2, 12, 16'h0006);
    run_count(32'h0000_8c85, 16'h0003, 0, 12, 16'h0003);
    rd(ADDR_STAT, stat(a_e, b_e, 1'b0));
    // One rise and one fall on the event line per edge code
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CFG, 32'h1030_8c05 | (32'(e) << 8));
      far.pulse_line(2, 2, 3);
      if (e == 1 || e == 2) a_e = ~a_e;
      rd(ADDR_STAT, stat(a_e, b_e, 1'b0));
    end
    rd(ADDR_CNT, 32'h0000_0003);
    wr(ADDR_CFG, 32'h0020_9105);
    repeat (2) @(posedge clk);
    `CHK("oe_b", 1'b0, io_b_oe)
    `CHK("pin_a", 1'b1, io_a)
    far.drive_b(1'b1);
    `CHK("pin_a", 1'b0, io_a)
    rd(ADDR_CNT, WORD_ZERO);
    repeat (2) @(posedge clk);
    `CHK("pending", 0, expq.size())
    test_done();
  end
endmodule
